// file: rtl/cdsc_top.sv
// Clock divider sync control, output mode and output disable logic
`timescale 1ns/1ps
module cdsc_top
   import cdsc_pkg::*;
#(
   parameter int DIV_W = 3
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire cdsc_wr_t         reg_wr,
   input  wire logic [8:0]       reg_rd_addr,
   output logic      [7:0]       reg_rdata,
   input  wire logic             sync_in,
   input  wire logic [DIV_W-1:0] div_ratio,
   input  wire logic             output_disable_pin,
   output logic                  out_enable,
   output logic                  out_lvds,
   output logic                  div_clk,
   output logic                  sync_applied
);

   //------------------------------------------------------------
   // Parameter check
   //------------------------------------------------------------
   generate
      if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div_w
         $error("DIV_W must lie between 1 and 8");
      end
   endgenerate

   //------------------------------------------------------------
   // Address decode
   //------------------------------------------------------------
   function automatic logic cdsc_hit(
      input logic [8:0] addr,
      input logic [8:0] reg_addr
   );
      return addr == reg_addr;
   endfunction

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   logic [7:0]       sync_ctrl_q;
   logic [7:0]       sync_ctrl_d;
   logic             lvds_q;
   logic             lvds_d;
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic             div_clk_q;
   logic             div_clk_d;
   logic             applied_q;
   logic             applied_d;
   logic             oe_q;
   logic             oe_d;
   logic [7:0]       rdata_q;
   logic [7:0]       rdata_d;

   //------------------------------------------------------------
   // Register port decode
   //------------------------------------------------------------
   wire logic wr_sync = reg_wr.wr_en &&
                        cdsc_hit(reg_wr.addr, CDSC_SYNC_CTRL_ADDR);
   wire logic wr_mode = reg_wr.wr_en &&
                        cdsc_hit(reg_wr.addr, CDSC_OUT_MODE_ADDR);
   wire logic rd_sync = cdsc_hit(reg_rd_addr, CDSC_SYNC_CTRL_ADDR);
   wire logic rd_mode = cdsc_hit(reg_rd_addr, CDSC_OUT_MODE_ADDR);

   //------------------------------------------------------------
   // Sync control write value
   //------------------------------------------------------------
   wire logic [7:0] ctrl_wr_val;

   generate
      for (genvar gi = 0; gi < 8; gi++) begin : g_ctrl_bit
         if (CDSC_SYNC_CTRL_MASK[gi]) begin : g_live
            assign ctrl_wr_val[gi] = reg_wr.wdata[gi];
         end else begin : g_rsvd
            assign ctrl_wr_val[gi] = 1'b0;
         end
      end
   endgenerate

   //------------------------------------------------------------
   // Sync gating
   //------------------------------------------------------------
   // master gate
   wire logic master_on = sync_ctrl_q[CDSC_MASTER_BIT];
   wire logic div_gate  = master_on && sync_ctrl_q[CDSC_DIV_SYNC_BIT];
   wire logic next_only = sync_ctrl_q[CDSC_NEXT_ONLY_BIT];
   wire logic sync_take = div_gate && sync_in;
   wire logic one_shot  = sync_take && next_only;

   always_comb begin
      sync_ctrl_d = sync_ctrl_q;
      if (wr_sync) begin
         sync_ctrl_d = ctrl_wr_val;
      end
      if (one_shot) begin
         sync_ctrl_d[CDSC_DIV_SYNC_BIT] = 1'b0;
      end
   end

   //------------------------------------------------------------
   // Input clock divider
   //------------------------------------------------------------
   // restart on sync
   wire logic cnt_wrap = cnt_q >= div_ratio;
   always_comb begin
      cnt_d     = cnt_wrap ? '0 : cnt_q + DIV_W'(1);
      div_clk_d = cnt_wrap ? ~div_clk_q : div_clk_q;
      if (sync_take) begin
         cnt_d     = '0;
         div_clk_d = 1'b0;
      end
   end

   //------------------------------------------------------------
   // Output control
   //------------------------------------------------------------
   // LVDS select write
   assign lvds_d    = wr_mode ? reg_wr.wdata[CDSC_OUT_TYPE_BIT] : lvds_q;
   assign oe_d      = ~output_disable_pin;
   assign applied_d = sync_take;

   //------------------------------------------------------------
   // Read data select
   //------------------------------------------------------------
   wire logic [7:0] mode_rd = 8'(lvds_q) << CDSC_OUT_TYPE_BIT;
   assign rdata_d = rd_sync ? sync_ctrl_q :
                    rd_mode ? mode_rd     : 8'h00;

   //------------------------------------------------------------
   // Sync control register
   //------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync_ctrl_q <= CDSC_SYNC_CTRL_RST;
      end else begin
         sync_ctrl_q <= sync_ctrl_d;
      end
   end

   //------------------------------------------------------------
   // Divider count
   //------------------------------------------------------------
   // count restart
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   //------------------------------------------------------------
   // Divided clock
   //------------------------------------------------------------
   // phase restart
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_clk_q <= 1'b0;
      end else begin
         div_clk_q <= div_clk_d;
      end
   end

   //------------------------------------------------------------
   // Sync applied flag
   //------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         applied_q <= 1'b0;
      end else begin
         applied_q <= applied_d;
      end
   end

   //------------------------------------------------------------
   // Read data register
   //------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   //------------------------------------------------------------
   // Output mode register
   //------------------------------------------------------------
   // power up CMOS
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lvds_q <= CDSC_OUT_MODE_RST[CDSC_OUT_TYPE_BIT];
      end else begin
         lvds_q <= lvds_d;
      end
   end

   //------------------------------------------------------------
   // Output enable register
   //------------------------------------------------------------
   // output disable pin
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign reg_rdata    = rdata_q;
   assign out_enable   = oe_q;
   assign out_lvds     = lvds_q;
   assign div_clk      = div_clk_q;
   assign sync_applied = applied_q;

endmodule

// file: rtl/cdsc_pkg.sv
// Constants and types for the clock divider sync control block
//------------------------------------------------------------
package cdsc_pkg;

   //------------------------------------------------------------
   // Register map
   //------------------------------------------------------------
   localparam logic [8:0] CDSC_SYNC_CTRL_ADDR  = 9'h100;
   localparam logic [8:0] CDSC_OUT_MODE_ADDR   = 9'h014;
   localparam logic [7:0] CDSC_SYNC_CTRL_RST   = 8'h00;
   localparam logic [7:0] CDSC_OUT_MODE_RST    = 8'h00;
   localparam int         CDSC_MASTER_BIT      = 0;
   localparam int         CDSC_DIV_SYNC_BIT    = 1;
   localparam int         CDSC_NEXT_ONLY_BIT   = 2;
   localparam int         CDSC_OUT_TYPE_BIT    = 6;
   localparam logic [7:0] CDSC_SYNC_CTRL_MASK  = 8'h07;
   localparam logic [2:0] CDSC_DIV_RATIO_RST   = 3'h0;

   //------------------------------------------------------------
   // Register write request
   //------------------------------------------------------------
   typedef struct packed {
      logic       wr_en;
      logic [8:0] addr;
      logic [7:0] wdata;
   } cdsc_wr_t;

endpackage

// file: dv/cdsc_top_asserts.sv
// Assertions for the sync control block
`timescale 1ns/1ps
module cdsc_top_asserts
   import cdsc_pkg::*;
#(
   parameter int DIV_W = 3
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire cdsc_wr_t         reg_wr,
   input  wire logic [8:0]       reg_rd_addr,
   input  wire logic [7:0]       reg_rdata,
   input  wire logic             sync_in,
   input  wire logic [DIV_W-1:0] div_ratio,
   input  wire logic             output_disable_pin,
   input  wire logic             out_enable,
   input  wire logic             out_lvds,
   input  wire logic             div_clk,
   input  wire logic             sync_applied
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_sync_cause: assert property (sync_applied |-> $past(sync_in))
      else $error("stray sync");
   a_sync_refused: assert property (
      $past(reg_rd_addr) == CDSC_SYNC_CTRL_ADDR &&
      !(reg_rdata[CDSC_MASTER_BIT] && reg_rdata[CDSC_DIV_SYNC_BIT])
      |-> !sync_applied)
      else $error("sync applied while gated off");
   a_master_held: assert property (sync_applied &&
      $past(reg_rd_addr) == CDSC_SYNC_CTRL_ADDR |-> reg_rdata[0])
      else $error("master low");
   a_oneshot_clear: assert property (
      sync_applied && reg_rdata[CDSC_NEXT_ONLY_BIT] &&
      $past(reg_rd_addr) == CDSC_SYNC_CTRL_ADDR &&
      reg_rd_addr == CDSC_SYNC_CTRL_ADDR
      |=> !reg_rdata[CDSC_DIV_SYNC_BIT])
      else $error("enable kept");
   a_phase_restart: assert property (sync_applied |-> !div_clk)
      else $error("phase");
   a_pin_disable: assert property (!$past(rst) |->
      out_enable == !$past(output_disable_pin)) else $error("oe");
   a_rsvd_zero: assert property ($past(reg_rd_addr) ==
      CDSC_SYNC_CTRL_ADDR |-> reg_rdata[7:3] == 5'h0) else $error("rsvd");
   a_lvds_rise: assert property ($rose(out_lvds) |->
      $past(reg_wr.wr_en) && $past(reg_wr.addr) == CDSC_OUT_MODE_ADDR)
      else $error("lvds up");
   a_lvds_fall: assert property ($fell(out_lvds) |->
      $past(reg_wr.wr_en) && $past(reg_wr.addr) == CDSC_OUT_MODE_ADDR)
      else $error("lvds down");
endmodule
bind cdsc_top cdsc_top_asserts #(
   .DIV_W(DIV_W)
) u_chk (
   .sys_clk            (sys_clk),
   .rst                (rst),
   .reg_wr             (reg_wr),
   .reg_rd_addr        (reg_rd_addr),
   .reg_rdata          (reg_rdata),
   .sync_in            (sync_in),
   .div_ratio          (div_ratio),
   .output_disable_pin (output_disable_pin),
   .out_enable         (out_enable),
   .out_lvds           (out_lvds),
   .div_clk            (div_clk),
   .sync_applied       (sync_applied)
);

// file: dv/cdsc_host.sv
// Host model driving the register port and sync line
`timescale 1ns/1ps
module cdsc_host
   import cdsc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sync_applied,
   input  wire logic [7:0] reg_rdata,
   output cdsc_wr_t        reg_wr,
   output logic [8:0]      reg_rd_addr,
   output logic            sync_in
);
   initial begin
      reg_wr      = '0;
      reg_rd_addr = CDSC_SYNC_CTRL_ADDR;
      sync_in     = 1'b0;
   end
   task wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge sys_clk) #1 reg_wr = '{1'b1, a, d};
      @(posedge sys_clk) #1 reg_wr = '{1'b0, ~a, ~d};
   endtask
   task idle;
      wr(CDSC_SYNC_CTRL_ADDR, 8'h00);
   endtask
   task rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge sys_clk) #1 reg_rd_addr = a;
      @(posedge sys_clk) #1 d = reg_rdata;
   endtask
   task sync(output logic s);
      @(posedge sys_clk) #1 sync_in = 1'b1;
      @(posedge sys_clk) #1 sync_in = 1'b0;
      s = sync_applied;
   endtask
endmodule

// file: dv/tb_clock_divider_sync_control.sv
// Testbench for the sync control block
`timescale 1ns/1ps
module tb_clock_divider_sync_control import cdsc_pkg::*; ;
   logic sys_clk = 0, rst = 1, output_disable_pin = 1, sync_in, s;
   logic out_enable, out_lvds, div_clk, sync_applied;
   cdsc_wr_t reg_wr;
   logic [8:0] reg_rd_addr;
   logic [7:0] reg_rdata, d;
   logic [2:0] div_ratio = 3'h2;
   int mismatches = 0, n_checks = 0, cyc = 0;
   always #5 sys_clk = ~sys_clk;
   cdsc_top #(.DIV_W(3)) DUT (.sys_clk, .rst, .reg_wr, .reg_rd_addr,
      .reg_rdata, .sync_in, .div_ratio, .output_disable_pin,
      .out_enable, .out_lvds, .div_clk, .sync_applied);
   cdsc_host u_host (.sys_clk, .sync_applied, .reg_rdata, .reg_wr,
      .reg_rd_addr, .sync_in);
   task chk(input logic [7:0] g, e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         mismatches++;
         end_of_test;
      end
   end
   task t_regs;
      u_host.wr(CDSC_SYNC_CTRL_ADDR, 8'hF8);
      u_host.rd(9'h0AA, d);
      chk(d, 8'h00);
      u_host.rd(CDSC_SYNC_CTRL_ADDR, d);
      chk(d, 8'h00);
      $display("t_regs done");
   endtask
   task t_gate;
      u_host.wr(CDSC_SYNC_CTRL_ADDR, 8'h02);
      u_host.sync(s);
      chk(s, 1'b0);
      u_host.wr(CDSC_SYNC_CTRL_ADDR, 8'h01);
      u_host.sync(s);
      chk(s, 1'b0);
      u_host.wr(CDSC_SYNC_CTRL_ADDR, 8'h03);
      repeat (2) begin
         u_host.sync(s);
         chk(s, 1'b1);
      end
      $display("t_gate done");
   endtask
   task t_phase;
      u_host.sync(s);
      chk(s, 1'b1);
      chk(div_clk, 1'b0);
      repeat (div_ratio) @(posedge sys_clk);
      #1;
      chk(div_clk, 1'b0);
      @(posedge sys_clk) #1;
      chk(div_clk, 1'b1);
      $display("t_phase done");
   endtask
   task t_once;
      u_host.wr(CDSC_SYNC_CTRL_ADDR, 8'h07);
      u_host.sync(s);
      chk(s, 1'b1);
      chk(div_clk, 1'b0);
      u_host.rd(CDSC_SYNC_CTRL_ADDR, d);
      chk(d, 8'h05);
      u_host.sync(s);
      chk(s, 1'b0);
      $display("t_once done");
   endtask
   task t_out;
      chk(out_lvds, 1'b0);
      chk(out_enable, 1'b0);
      u_host.wr(CDSC_OUT_MODE_ADDR, 8'h40);
      chk(out_lvds, 1'b1);
      u_host.rd(CDSC_OUT_MODE_ADDR, d);
      chk(d, 8'h40);
      output_disable_pin = 1'b0;
      @(posedge sys_clk) #1;
      chk(out_enable, 1'b1);
      u_host.wr(CDSC_OUT_MODE_ADDR, 8'h00);
      chk(out_lvds, 1'b0);
      output_disable_pin = 1'b1;
      @(posedge sys_clk) #1;
      chk(out_enable, 1'b0);
      $display("t_out done");
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      #1 rst = 0;
      t_out;
      t_regs;
      t_gate;
      t_phase;
      t_once;
      u_host.idle;
      end_of_test;
   end
endmodule
